// File: common/rpls_pkg.sv
// Shared constants for the reset and PLL lock sequencer.
// Assumes clk_sys is the oscillator clock, so every count is in oscillator cycles.
package rpls_pkg;

   // ==========================================================
   // Clock and reset timing
   // ==========================================================
   localparam int unsigned CLK_HZ        = 25000000;
   localparam int unsigned RST_LOW_CYC   = 8;
   localparam int unsigned WDOG_CYC      = 512;
   localparam int unsigned POST_CYC      = 32;
   localparam int unsigned BOOT_SMP_CYC  = 16;
   localparam int unsigned BOOT_HOLD_CYC = 200;
   localparam int unsigned LOCK_CYC      = 131072;

   // ==========================================================
   // Clock ratio codes, in units of half the oscillator clock
   // ==========================================================
   localparam logic [3:0] RATIO_HALF  = 4'h1;
   localparam logic [3:0] RATIO_RESET = 4'h2;
   localparam logic [3:0] RATIO_X2    = 4'h4;
   localparam logic [3:0] RATIO_X4    = 4'h8;

   // ==========================================================
   // Peripheral clock reset divisions
   // ==========================================================
   localparam logic [2:0] FAST_DIV_RST = 3'h2;
   localparam logic [2:0] SLOW_DIV_RST = 3'h4;

   // Sequencer states, one-hot.
   typedef enum logic [3:0] {
      RPLS_ST_RESET = 4'h1,
      RPLS_ST_WAIT  = 4'h2,
      RPLS_ST_RUN   = 4'h4,
      RPLS_ST_WDOG  = 4'h8
   } rpls_st_t;

endpackage : rpls_pkg

// File: hw/rpls_clkdiv.sv
// Clock enable divider: one-cycle tick every div cycles of clk_sys.
// Assumes div is at least one and is held steady while clr is low.
module rpls_clkdiv #(
   parameter int unsigned W = 3
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   input  wire logic         clr,
   input  wire logic [W-1:0] div,
   output logic              tick
);
   import rpls_pkg::*;

   typedef struct packed {
      logic [W-1:0] cnt;
      logic         tick;
   } rpls_div_t;

   rpls_div_t q;
   rpls_div_t d;

   // ==========================================================
   // Next state
   // ==========================================================
   // Counts up to div minus one and pulses tick on the wrap.
   always_comb
   begin
      d = q;
      d.tick = 1'b0;
      if (clr)
      begin
         d.cnt = '0;
      end
      else if (q.cnt >= div - W'(1))
      begin
         d.cnt  = '0;
         d.tick = 1'b1;
      end
      else
      begin
         d.cnt = q.cnt + W'(1);
      end
   end

   // Register the state.
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign tick = q.tick;

endmodule : rpls_clkdiv

// File: hw/rpls_top.sv
// Reset and PLL lock sequencer: reset pin filter, watchdog reset pulse,
// post-reset bus delay, boot pin capture and system clock ratio switching.
// Assumes clk_sys is the oscillator clock and the pin inputs are asynchronous.
//
// Notes on behaviour
// - A watchdog event outside reset drives the reset pin low for 512 cycles.
// - After core reset release, bus activity starts 32 cycles later.
// - A ratio write outside reset starts lock at once; system clock runs at half oscillator.
// - Lock lasts 131072 cycles, then the new ratio takes effect.
// - Ratio 0x0004 gives twice, 0x0008 four times the oscillator clock.
// - Out of reset, peripheral clocks divide system clock by two and four.
module rpls_top #(
   parameter int unsigned LOCK_CYCLES = rpls_pkg::LOCK_CYC,
   parameter int unsigned BOOT_W      = 4
) (
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   input  wire logic              device_reset_pin_i,
   output logic                   device_reset_pin_o,
   output logic                   device_reset_pin_oe,
   input  wire logic              wdog_trigger,
   input  wire logic [BOOT_W-1:0] boot_mode_pins,
   input  wire logic              pll_ratio_ctrl_wr,
   input  wire logic [3:0]        pll_ratio_ctrl_wdata,
   output logic                   core_reset_n,
   output logic                   bus_active,
   output logic [BOOT_W-1:0]      boot_mode,
   output logic                   boot_mode_valid,
   output logic [3:0]             system_clock_ratio,
   output logic                   pll_locking,
   output logic [2:0]             fast_periph_div,
   output logic [2:0]             slow_periph_div,
   output logic                   fast_periph_clock_en,
   output logic                   slow_periph_clock_en
);
   import rpls_pkg::*;

   localparam int unsigned LW = $clog2(LOCK_CYCLES);

   typedef struct packed {
      rpls_st_t          st;
      logic [2:0]        pin_s;
      logic              pin_lvl;
      logic [3:0]        low_cnt;
      logic              seen_low;
      logic [7:0]        post_cnt;
      logic [9:0]        wd_cnt;
      logic [LW-1:0]     lock_cnt;
      logic              locking;
      logic [3:0]        ratio;
      logic [3:0]        pend;
      logic              bus_act;
      logic              core_rn;
      logic [BOOT_W-1:0] boot_s0;
      logic [BOOT_W-1:0] boot_s1;
      logic [BOOT_W-1:0] boot_s2;
      logic [BOOT_W-1:0] boot;
      logic              boot_vld;
      logic              pin_oe;
      logic              pin_o;
      logic [2:0]        fast_div;
      logic [2:0]        slow_div;
   } rpls_state_t;

   rpls_state_t q;
   rpls_state_t d;
   logic        running;
   logic        warm_hit;

   // ==========================================================
   // Next state
   // ==========================================================
   // Filters the pin, sequences reset and handles the ratio switch.
   always_comb
   begin
      d = q;
      running  = (q.st == RPLS_ST_WAIT) || (q.st == RPLS_ST_RUN);
      warm_hit = 1'b0;
      // Three-stage synchronisers; a level counts once stages two and three agree.
      d.pin_s   = {q.pin_s[1:0], device_reset_pin_i};
      d.boot_s0 = boot_mode_pins;
      d.boot_s1 = q.boot_s0;
      d.boot_s2 = q.boot_s1;
      if (q.pin_s[1] == q.pin_s[2])
      begin
         d.pin_lvl = q.pin_s[1];
      end
      // Low-time filter; eight or more filtered low cycles count as a reset.
      if (!q.pin_lvl)
      begin
         if (q.low_cnt < 4'(RST_LOW_CYC - 1))
         begin
            d.low_cnt = q.low_cnt + 4'h1;
         end
         else
         begin
            d.seen_low = 1'b1;
            warm_hit   = 1'b1;
         end
      end
      else
      begin
         d.low_cnt = 4'h0;
      end
      // A ratio write restarts lock and drops to half the oscillator clock.
      if (running && pll_ratio_ctrl_wr)
      begin
         d.locking  = 1'b1;
         d.ratio    = RATIO_HALF;
         d.pend     = pll_ratio_ctrl_wdata;
         d.lock_cnt = '0;
      end
      else if (q.locking)
      begin
         if (q.lock_cnt == LW'(LOCK_CYCLES - 1))
         begin
            d.locking = 1'b0;
            d.ratio   = q.pend;
         end
         else
         begin
            d.lock_cnt = q.lock_cnt + LW'(1);
         end
      end
      case (q.st)
         RPLS_ST_RESET:
         begin
            d.core_rn = 1'b0;
            if (q.seen_low && q.pin_lvl)
            begin
               d.st       = RPLS_ST_WAIT;
               d.seen_low = 1'b0;
               d.post_cnt = 8'h00;
               d.core_rn  = 1'b1;
            end
         end
         RPLS_ST_WAIT:
         begin
            d.post_cnt = q.post_cnt + 8'h01;
            if (q.post_cnt == 8'(BOOT_SMP_CYC) && (q.boot_s1 == q.boot_s2))
            begin
               d.boot     = q.boot_s2;
               d.boot_vld = 1'b1;
            end
            if (q.post_cnt == 8'(POST_CYC - 1))
            begin
               d.st      = RPLS_ST_RUN;
               d.bus_act = 1'b1;
            end
         end
         RPLS_ST_RUN:
         begin
            d.bus_act = 1'b1;
         end
         RPLS_ST_WDOG:
         begin
            d.wd_cnt = q.wd_cnt + 10'h001;
            if (q.wd_cnt == 10'(WDOG_CYC - 1))
            begin
               d.wd_cnt   = q.wd_cnt;
               d.pin_oe   = 1'b0;
               d.st       = RPLS_ST_RESET;
               d.seen_low = 1'b1;
            end
         end
         default:
         begin
            d.st = RPLS_ST_RESET;
         end
      endcase
      // Entry into reset, by the pin or by the watchdog, restores clock defaults.
      if (running && (warm_hit || wdog_trigger))
      begin
         d.st       = RPLS_ST_RESET;
         d.core_rn  = 1'b0;
         d.bus_act  = 1'b0;
         d.boot_vld = 1'b0;
         d.locking  = 1'b0;
         d.ratio    = RATIO_RESET;
         d.fast_div = FAST_DIV_RST;
         d.slow_div = SLOW_DIV_RST;
         if (wdog_trigger)
         begin
            d.st     = RPLS_ST_WDOG;
            d.pin_oe = 1'b1;
            d.wd_cnt = 10'h000;
         end
      end
   end

   // Register the state; the pin output value is always low when enabled.
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q          <= '0;
         q.st       <= RPLS_ST_RESET;
         q.ratio    <= RATIO_RESET;
         q.pend     <= RATIO_RESET;
         q.fast_div <= FAST_DIV_RST;
         q.slow_div <= SLOW_DIV_RST;
      end
      else
      begin
         q <= d;
      end
   end

   // ==========================================================
   // Peripheral clock enables
   // ==========================================================
   // Ticks at the peripheral divisions of clk_sys, halted while the core is in reset.
   rpls_clkdiv #(.W(3)) u_fast_div (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .clr     (!q.core_rn),
      .div     (q.fast_div),
      .tick    (fast_periph_clock_en)
   );

   rpls_clkdiv #(.W(3)) u_slow_div (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .clr     (!q.core_rn),
      .div     (q.slow_div),
      .tick    (slow_periph_clock_en)
   );

   // Outputs straight from the state register.
   assign device_reset_pin_o  = q.pin_o;
   assign device_reset_pin_oe = q.pin_oe;
   assign core_reset_n        = q.core_rn;
   assign bus_active          = q.bus_act;
   assign boot_mode           = q.boot;
   assign boot_mode_valid     = q.boot_vld;
   assign system_clock_ratio  = q.ratio;
   assign pll_locking         = q.locking;
   assign fast_periph_div     = q.fast_div;
   assign slow_periph_div     = q.slow_div;

   // ==========================================================
   // Assertions
   // ==========================================================
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   sequence s_low8;
      (!q.pin_lvl)[*8];
   endsequence

   sequence s_lock_req;
      (running && pll_ratio_ctrl_wr && !wdog_trigger && !warm_hit);
   endsequence

   property p_wdog_start;
      $rose(device_reset_pin_oe) |-> (q.wd_cnt == 10'h000) && !device_reset_pin_o && !core_reset_n;
   endproperty
   a_wdog_start: assert property (p_wdog_start) else $error("Watchdog pulse started wrongly.");

   property p_wdog_len;
      $fell(device_reset_pin_oe) |-> $past(q.wd_cnt) == 10'(WDOG_CYC - 1);
   endproperty
   a_wdog_len: assert property (p_wdog_len) else $error("Watchdog pulse length wrong.");

   property p_bus_delay;
      $rose(bus_active) |-> $past(q.post_cnt) == 8'(POST_CYC - 1) && $past(q.st) == RPLS_ST_WAIT;
   endproperty
   a_bus_delay: assert property (p_bus_delay) else $error("Bus started at the wrong delay.");

   property p_bus_after_rel;
      $rose(core_reset_n) |-> !bus_active [*8];
   endproperty
   a_bus_after_rel: assert property (p_bus_after_rel) else $error("Bus active too soon after release.");

   property p_lock_start;
      s_lock_req |=> pll_locking && (system_clock_ratio == RATIO_HALF) && (q.lock_cnt == '0);
   endproperty
   a_lock_start: assert property (p_lock_start) else $error("Lock phase did not start.");

   property p_lock_half;
      pll_locking |-> system_clock_ratio == RATIO_HALF;
   endproperty
   a_lock_half: assert property (p_lock_half) else $error("Clock not halved during lock.");

   property p_lock_end;
      $fell(pll_locking) && core_reset_n |-> $past(q.lock_cnt) == LW'(LOCK_CYCLES - 1)
         && system_clock_ratio == q.pend;
   endproperty
   a_lock_end: assert property (p_lock_end) else $error("Lock ended at the wrong count.");

   property p_periph_dflt;
      !core_reset_n |-> fast_periph_div == FAST_DIV_RST && slow_periph_div == SLOW_DIV_RST;
   endproperty
   a_periph_dflt: assert property (p_periph_dflt) else $error("Peripheral defaults wrong in reset.");

   property p_warm;
      (s_low8 ##0 running) |=> !core_reset_n;
   endproperty
   a_warm: assert property (p_warm) else $error("Warm reset not recognised.");

   property p_release_sync;
      $rose(core_reset_n) |-> $past(q.pin_lvl) && $past(q.pin_s[1]) && $past(q.seen_low);
   endproperty
   a_release_sync: assert property (p_release_sync) else $error("Release not synchronised.");

endmodule : rpls_top

// File: sim/rpls_supervisor.sv
// Behavioural model of the board reset supervisor and the boot strap drivers.
// Assumes a pull-up on the reset pin and pulse lengths counted in clk_sys cycles.
module rpls_supervisor #(
   parameter int unsigned BOOT_W = 4
) (
   input  wire logic              clk_sys,
   input  wire logic              pin_oe,
   input  wire logic              pin_o,
   input  wire logic              low_go,
   input  wire logic [15:0]       low_len,
   input  wire logic [BOOT_W-1:0] boot_in,
   output logic                   pin_lvl,
   output logic [BOOT_W-1:0]      boot_pins
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Reset pin drive
   // ==========================================================
   // Power-up low lasts 25000 cycles, 1 ms at 25 MHz, counted from a good core supply.
   logic [15:0] low_cnt  = 16'h61A8;
   logic [8:0]  hold_cnt = 9'h0C8;
   // Counts down the requested low time; a new request restarts it.
   always @(posedge clk_sys)
   begin
      if (low_go)
         low_cnt <= low_len;
      else if (low_cnt != 16'h0000)
         low_cnt <= low_cnt - 16'h0001;
   end
   // The wire is low while either party pulls it down, else the pull-up wins.
   assign pin_lvl = (pin_oe ? pin_o : 1'b1) & (low_cnt == 16'h0000);
   // ==========================================================
   // Boot straps
   // ==========================================================
   // Straps hold while the pin is low and 200 cycles after release, then they change.
   always @(posedge clk_sys)
   begin
      if (!pin_lvl)
         hold_cnt <= 9'h0C8;
      else if (hold_cnt != 9'h000)
         hold_cnt <= hold_cnt - 9'h001;
   end
   assign boot_pins = (hold_cnt != 9'h000) ? boot_in : ~boot_in;
endmodule : rpls_supervisor

// File: sim/testbench.sv
// Self-checking bench for the reset and PLL lock sequencer.
// Assumes the supervisor model on the reset pin; inputs change at the falling edge.
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin errors++; \
   $display("wrong value %s expected %0d seen %0d", nm, exp, got); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import rpls_pkg::*;
   localparam int unsigned LOCK_SIM = 16;
   localparam logic [3:0]  STRAP    = 4'hA;
   logic       clk_sys = 1'b0, rst_n = 1'b0, wdog = 1'b0, wr = 1'b0, low_go = 1'b0;
   logic [3:0] wdata = 4'h0, boot_pins, boot_mode, ratio;
   logic [15:0] low_len = 16'h0000;
   logic       pin_lvl, pin_o, pin_oe, core_n, bus, valid, lock, f_en, s_en;
   logic [2:0] f_div, s_div;
   int         errors = 0, n_checks = 0;
   rpls_top #(.LOCK_CYCLES(LOCK_SIM), .BOOT_W(4)) u_rpls_top (.clk_sys(clk_sys), .rst_n(rst_n),
      .device_reset_pin_i(pin_lvl), .device_reset_pin_o(pin_o), .device_reset_pin_oe(pin_oe),
      .wdog_trigger(wdog), .boot_mode_pins(boot_pins), .pll_ratio_ctrl_wr(wr),
      .pll_ratio_ctrl_wdata(wdata), .core_reset_n(core_n), .bus_active(bus), .boot_mode(boot_mode),
      .boot_mode_valid(valid), .system_clock_ratio(ratio), .pll_locking(lock), .fast_periph_div(f_div),
      .slow_periph_div(s_div), .fast_periph_clock_en(f_en), .slow_periph_clock_en(s_en));
   rpls_supervisor #(.BOOT_W(4)) u_rpls_supervisor (.clk_sys(clk_sys), .pin_oe(pin_oe), .pin_o(pin_o),
      .low_go(low_go), .low_len(low_len), .boot_in(STRAP), .pin_lvl(pin_lvl), .boot_pins(boot_pins));
   // ==========================================================
   // Shared tasks
   // ==========================================================
   // Prints the counts and the verdict, then ends the run.
   task automatic wrap_up;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : wrap_up
   // Follows one release of the pin: sync delay, bus delay, strap capture, defaults.
   task automatic release_check(output bit seen);
      int n;
      seen = 1'b0;
      n = 0;
      while (pin_lvl !== 1'b1 && n < 30000)
      begin
         if (core_n === 1'b0) seen = 1'b1;
         @(negedge clk_sys);
         n++;
      end
      n = 0;
      while (!(seen && core_n === 1'b1) && n < 20)
      begin
         if (core_n === 1'b0) seen = 1'b1;
         @(negedge clk_sys);
         n++;
      end
      `CHK("sync delay in range", 1'b1, n >= 2 && n <= 6)
      n = 0;
      while (bus !== 1'b1 && n < 100)
      begin
         @(negedge clk_sys);
         n++;
      end
      `CHK("bus delay", 32, n)
      `CHK("boot valid", 1'b1, valid)
      `CHK("boot mode", STRAP, boot_mode)
      `CHK("reset ratio", RATIO_RESET, ratio)
   endtask : release_check
   // ==========================================================
   // Scenarios
   // ==========================================================
   // Power-up: core held, then released; peripheral defaults and tick rates.
   task automatic t_power_up;
      bit seen;
      int nf, ns;
      `CHK("core in power-up", 1'b0, core_n)
      `CHK("fast enable in reset", 1'b0, f_en)
      release_check(seen);
      `CHK("fast div", FAST_DIV_RST, f_div)
      `CHK("slow div", SLOW_DIV_RST, s_div)
      nf = 0;
      ns = 0;
      repeat (16)
      begin
         @(negedge clk_sys);
         nf += int'(f_en === 1'b1);
         ns += int'(s_en === 1'b1);
      end
      `CHK("fast ticks", 8, nf)
      `CHK("slow ticks", 4, ns)
      $display("test power_up done, errors %0d", errors);
   endtask : t_power_up
   // Warm reset pulse of len cycles; shorter than eight must be ignored.
   task automatic t_warm(input int len);
      bit seen;
      low_len = 16'(len);
      low_go = 1'b1;
      @(negedge clk_sys);
      low_go = 1'b0;
      if (len >= int'(RST_LOW_CYC))
      begin
         release_check(seen);
         `CHK("warm reset taken", 1'b1, seen)
      end
      else
      begin
         seen = 1'b0;
         repeat (20)
         begin
            @(negedge clk_sys);
            if (core_n === 1'b0) seen = 1'b1;
         end
         `CHK("short pulse ignored", 1'b0, seen)
      end
      $display("test warm %0d done, errors %0d", len, errors);
   endtask : t_warm
   // Watchdog pulse width, with a ratio write during reset that must be refused.
   task automatic t_wdog;
      bit seen;
      int n;
      wdog = 1'b1;
      @(negedge clk_sys);
      wdog = 1'b0;
      `CHK("pin driven", 1'b1, pin_oe)
      `CHK("pin driven low", 1'b0, pin_o)
      `CHK("core in watchdog", 1'b0, core_n)
      wr = 1'b1;
      wdata = RATIO_X4;
      @(negedge clk_sys);
      wr = 1'b0;
      n = 1;
      while (pin_oe === 1'b1 && n < 600)
      begin
         n++;
         @(negedge clk_sys);
      end
      `CHK("watchdog width", 512, n)
      release_check(seen);
      `CHK("no lock after reset", 1'b0, lock)
      $display("test watchdog done, errors %0d", errors);
   endtask : t_wdog
   // Ratio write: half rate during lock, lock length, then the new ratio.
   task automatic t_pll(input logic [3:0] code);
      int n;
      wr = 1'b1;
      wdata = code;
      @(negedge clk_sys);
      wr = 1'b0;
      `CHK("locking", 1'b1, lock)
      `CHK("ratio in lock", RATIO_HALF, ratio)
      n = 0;
      while (lock === 1'b1 && n < 100)
      begin
         n++;
         @(negedge clk_sys);
      end
      `CHK("lock length", LOCK_SIM, n)
      `CHK("new ratio", code, ratio)
      $display("test pll %0h done, errors %0d", code, errors);
   endtask : t_pll
   // ==========================================================
   // Clock, sequence and watchdog
   // ==========================================================
   // Oscillator clock at 25 MHz.
   initial
   begin
      forever #20 clk_sys = ~clk_sys;
   end
   // Holds reset 20 cycles, then runs every scenario.
   initial
   begin
      repeat (20) @(negedge clk_sys);
      rst_n = 1'b1;
      t_power_up();
      t_warm(7);
      t_warm(8);
      t_wdog();
      t_pll(RATIO_X2);
      t_pll(RATIO_X4);
      // The last pulse is the power-down warning: the pin stays low 200 cycles, 8 us at 25 MHz.
      t_warm(200);
      wrap_up();
   end
   // Cuts a hang short well beyond the expected run of under 28000 cycles.
   initial
   begin
      repeat (40000) @(posedge clk_sys);
      errors++;
      wrap_up();
   end
endmodule : testbench
